// ==== design/i2cm_defines.svh ====
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define I2CM_OFS_CTRL_A    8'h00
`define I2CM_OFS_CTRL_B    8'h04
`define I2CM_OFS_STATUS    8'h08
`define I2CM_OFS_INT_FLAG  8'h0C
`define I2CM_OFS_SYNC_BUSY 8'h10
`define I2CM_OFS_ADDR      8'h14
`define I2CM_OFS_DATA      8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define I2CM_BIT_SOFT_RST   0
`define I2CM_BIT_ENABLE     1
`define I2CM_BIT_SMART      8
`define I2CM_BIT_STRETCH    11
`define I2CM_BIT_CMD        16
`define I2CM_BIT_ACK_ACTION 18
`define I2CM_BIT_ARB_LOSS   1
`define I2CM_BIT_NACK_RX    2
`define I2CM_BIT_HOLD       3
`define I2CM_BIT_MASTER_BUS 0
`define I2CM_BIT_SLAVE_BUS  1
`define I2CM_BIT_SYNC_CTLB  2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define I2CM_RESET_VALUE   32'h00000000
`define I2CM_SYNC_CYCLES   4
`define I2CM_SCL_PERIOD_NS 10000
`define I2CM_CLK_PERIOD_NS 25
`define I2CM_QTR_CYCLES    (`I2CM_SCL_PERIOD_NS / (4 * `I2CM_CLK_PERIOD_NS))

`endif

// ==== design/i2cm_pkg.sv ====
package i2cm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BITS  = 3'b010,
		ST_HOLD  = 3'b011,
		ST_STOP  = 3'b100
	} i2cm_state_type;

	typedef enum logic [1:0] {
		K_ADDR    = 2'b00,
		K_TX      = 2'b01,
		K_RX      = 2'b10,
		K_ACKSTOP = 2'b11
	} i2cm_kind_type;

	typedef enum logic [1:0] {
		CMD_NONE = 2'b00,
		CMD_RSVD = 2'b01,
		CMD_READ = 2'b10,
		CMD_STOP = 2'b11
	} i2cm_cmd_type;

	typedef struct packed {
		i2cm_state_type state;
		i2cm_kind_type  kind;
		logic [1:0]     qtr;
		logic [11:0]    cnt;
		logic [8:0]     shift;
		logic [7:0]     rx;
		logic [3:0]     bits;
		logic [7:0]     data;
		logic [7:0]     addr;
		logic           readDir;
		logic           sclOe;
		logic           sdaOe;
		logic           masterOnBus;
		logic           slaveOnBus;
		logic           arbitration_lost_flag;
		logic           received_nack_flag;
		logic           enable;
		logic           enReq;
		logic           softRst;
		logic           syncEn;
		logic           syncB;
		logic [3:0]     syncCnt;
		logic           smart;
		logic           clkStretch;
		logic           ackAction;
		logic           pSmart;
		logic           pStretch;
		logic           pAck;
		i2cm_cmd_type   pCmd;
		logic [31:0]    prdata;
		logic           sclMeta;
		logic           sclSync;
		logic           sdaMeta;
		logic           sdaSync;
	} i2cm_regs_type;
endpackage

// ==== design/i2cm_master.sv ====
`timescale 1ns/100ps
`include "i2cm_defines.svh"

// How it works
// - write address acked: flag, clear nack, hold
// - then data, repeated start, or stop
// - read address acked: receive byte, flag, hold
// - smart mode sends ack action automatically
// - data write starts byte, collisions watched
// - collision sets arbitration lost; ack clears nack
// - master flag after every transmitted packet except an acked read address
// - enable write sets busy until done
// - soft reset clears registers, disables unit
// - soft reset write ignores other fields
// - during reset: writes error, reads reset
// - soft reset and busy clear together
// - control B smart and stretch fields protected while enabled, synchronized
module i2cm_master #(
	parameter int QTR_CYCLES  = `I2CM_QTR_CYCLES,
	parameter int SYNC_CYCLES = `I2CM_SYNC_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        sclIn,
	output wire logic        sclOut,
	output wire logic        sclOe,
	input  wire logic        sdaIn,
	output wire logic        sdaOut,
	output wire logic        sdaOe
);
	i2cm_pkg::i2cm_regs_type r_q;
	i2cm_pkg::i2cm_regs_type r_d;
	logic busy, wrOk, rdSet, rdHold, wrHold;
	logic actAddr, actData, smartRd, cmdFire, tick, step, smp;

	// ----------------------------------------
	// bus and pin glue
	// ----------------------------------------
	assign pready  = 1'b1;
	assign prdata  = r_q.prdata;
	assign sclOut  = 1'b0;
	assign sdaOut  = 1'b0;
	assign sclOe   = r_q.sclOe;
	assign sdaOe   = r_q.sdaOe;
	assign busy    = r_q.softRst | r_q.syncEn | r_q.syncB;
	assign pslverr = psel & penable & pwrite & (r_q.softRst | (busy &
		(paddr == `I2CM_OFS_CTRL_A | paddr == `I2CM_OFS_CTRL_B)));
	assign wrOk    = psel & penable & pwrite & ~pslverr;
	assign rdSet   = psel & ~penable & ~pwrite;
	assign rdHold  = r_q.state == i2cm_pkg::ST_HOLD & r_q.readDir;
	assign wrHold  = r_q.state == i2cm_pkg::ST_HOLD & ~r_q.readDir;
	assign actAddr = wrOk & paddr == `I2CM_OFS_ADDR & r_q.enable &
		(r_q.state == i2cm_pkg::ST_IDLE | r_q.state == i2cm_pkg::ST_HOLD);
	assign actData = wrOk & paddr == `I2CM_OFS_DATA & r_q.enable & wrHold;
	assign smartRd = rdSet & paddr == `I2CM_OFS_DATA & r_q.smart & rdHold;
	assign cmdFire = r_q.syncB & r_q.syncCnt == 4'h0 & ~r_q.softRst;
	assign tick    = r_q.cnt == 12'h000;
	assign step    = tick & ~(r_q.qtr == 2'h2 & ~r_q.sclSync);
	assign smp     = r_q.sdaSync;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.sclMeta = sclIn;
		r_d.sclSync = r_q.sclMeta;
		r_d.sdaMeta = sdaIn;
		r_d.sdaSync = r_q.sdaMeta;
		r_d.cnt = tick ? 12'(QTR_CYCLES - 1) : r_q.cnt - 12'h001;

		if (busy) begin
			r_d.syncCnt = r_q.syncCnt - 4'h1;
			if (r_q.syncCnt == 4'h0) begin
				r_d.syncEn = 1'b0;
				r_d.syncB = 1'b0;
				if (r_q.syncEn)
					r_d.enable = r_q.enReq;
				if (r_q.syncB) begin
					r_d.smart = r_q.pSmart;
					r_d.clkStretch = r_q.pStretch;
					r_d.ackAction = r_q.pAck;
				end
			end
		end

		if (wrOk) begin
			case (paddr)
				`I2CM_OFS_CTRL_A: begin
					if (pwdata[`I2CM_BIT_SOFT_RST]) begin
						r_d.softRst = 1'b1;
						r_d.syncCnt = 4'(SYNC_CYCLES - 1);
					end else if (pwdata[`I2CM_BIT_ENABLE] != r_q.enReq) begin
						r_d.enReq = pwdata[`I2CM_BIT_ENABLE];
						r_d.syncEn = 1'b1;
						r_d.syncCnt = 4'(SYNC_CYCLES - 1);
					end
				end
				`I2CM_OFS_CTRL_B: begin
					r_d.pSmart = r_q.enable ? r_q.smart : pwdata[`I2CM_BIT_SMART];
					r_d.pStretch = r_q.enable ? r_q.clkStretch : pwdata[`I2CM_BIT_STRETCH];
					r_d.pAck = pwdata[`I2CM_BIT_ACK_ACTION];
					r_d.pCmd = i2cm_pkg::i2cm_cmd_type'(pwdata[`I2CM_BIT_CMD +: 2]);
					r_d.syncB = 1'b1;
					r_d.syncCnt = 4'(SYNC_CYCLES - 1);
				end
				`I2CM_OFS_STATUS: if (pwdata[`I2CM_BIT_ARB_LOSS]) r_d.arbitration_lost_flag = 1'b0;
				`I2CM_OFS_INT_FLAG: begin
					if (pwdata[`I2CM_BIT_MASTER_BUS]) r_d.masterOnBus = 1'b0;
					if (pwdata[`I2CM_BIT_SLAVE_BUS]) r_d.slaveOnBus = 1'b0;
				end
				`I2CM_OFS_ADDR: r_d.addr = pwdata[7:0];
				default: ;
			endcase
		end

		if (rdSet) begin
			r_d.prdata = `I2CM_RESET_VALUE;
			case (paddr)
				`I2CM_OFS_CTRL_A: r_d.prdata[`I2CM_BIT_ENABLE] = r_q.enable & r_q.enReq;
				`I2CM_OFS_CTRL_B: begin
					r_d.prdata[`I2CM_BIT_SMART] = r_q.smart;
					r_d.prdata[`I2CM_BIT_STRETCH] = r_q.clkStretch;
					r_d.prdata[`I2CM_BIT_ACK_ACTION] = r_q.ackAction;
				end
				`I2CM_OFS_STATUS: begin
					r_d.prdata[`I2CM_BIT_ARB_LOSS] = r_q.arbitration_lost_flag;
					r_d.prdata[`I2CM_BIT_NACK_RX] = r_q.received_nack_flag;
					r_d.prdata[`I2CM_BIT_HOLD] = r_q.state == i2cm_pkg::ST_HOLD;
				end
				`I2CM_OFS_INT_FLAG: begin
					r_d.prdata[`I2CM_BIT_MASTER_BUS] = r_q.masterOnBus;
					r_d.prdata[`I2CM_BIT_SLAVE_BUS] = r_q.slaveOnBus;
				end
				`I2CM_OFS_SYNC_BUSY: begin
					r_d.prdata[`I2CM_BIT_ENABLE] = r_q.syncEn;
					r_d.prdata[`I2CM_BIT_SYNC_CTLB] = r_q.syncB;
				end
				`I2CM_OFS_ADDR: r_d.prdata[7:0] = r_q.addr;
				`I2CM_OFS_DATA: r_d.prdata[7:0] = r_q.data;
				default: ;
			endcase
			if (r_q.softRst) begin
				r_d.prdata = `I2CM_RESET_VALUE;
				if (paddr == `I2CM_OFS_CTRL_A | paddr == `I2CM_OFS_SYNC_BUSY)
					r_d.prdata[`I2CM_BIT_SOFT_RST] = 1'b1;
			end
		end

		// ----------------------------------------
		// launch from idle or hold
		// ----------------------------------------
		// three ways onward
		if (actAddr | actData | ((smartRd | (cmdFire & r_q.pCmd != i2cm_pkg::CMD_NONE)) &
			r_q.state == i2cm_pkg::ST_HOLD)) begin
			r_d.qtr = 2'h0;
			r_d.cnt = 12'(QTR_CYCLES - 1);
			r_d.masterOnBus = 1'b0;
			r_d.slaveOnBus = 1'b0;
			r_d.bits = 4'h9;
			r_d.state = i2cm_pkg::ST_BITS;
			if (actAddr) begin
				r_d.shift = {pwdata[7:0], 1'b1};
				r_d.kind = i2cm_pkg::K_ADDR;
				r_d.state = i2cm_pkg::ST_START;
			end else if (actData) begin
				r_d.shift = {pwdata[7:0], 1'b1};
				r_d.kind = i2cm_pkg::K_TX;
			end else if (r_q.pCmd == i2cm_pkg::CMD_STOP & cmdFire) begin
				r_d.shift = {r_d.ackAction, 8'hFF};
				r_d.bits = 4'h1;
				r_d.kind = i2cm_pkg::K_ACKSTOP;
				if (!r_q.readDir)
					r_d.state = i2cm_pkg::ST_STOP;
			end else if (r_q.readDir) begin
				r_d.shift = {r_d.ackAction, 8'hFF};
				r_d.kind = i2cm_pkg::K_RX;
			end else begin
				r_d.state = i2cm_pkg::ST_HOLD;
			end
		end

		// ----------------------------------------
		// bit engine
		// ----------------------------------------
		if (step) begin
			case (r_q.state)
				i2cm_pkg::ST_START: begin
					r_d.qtr = r_q.qtr + 2'h1;
					case (r_q.qtr)
						2'h0: r_d.sdaOe = 1'b0;
						2'h1: r_d.sclOe = 1'b0;
						2'h2: r_d.sdaOe = 1'b1;
						default: begin
							r_d.sclOe = 1'b1;
							r_d.state = i2cm_pkg::ST_BITS;
						end
					endcase
				end
				i2cm_pkg::ST_STOP: begin
					r_d.qtr = r_q.qtr + 2'h1;
					case (r_q.qtr)
						2'h0: r_d.sdaOe = 1'b1;
						2'h1: r_d.sclOe = 1'b0;
						2'h2: r_d.sdaOe = 1'b0;
						default: begin
							r_d.readDir = 1'b0;
							r_d.state = i2cm_pkg::ST_IDLE;
						end
					endcase
				end
				i2cm_pkg::ST_BITS: begin
					r_d.qtr = r_q.qtr + 2'h1;
					case (r_q.qtr)
						2'h0: r_d.sdaOe = ~r_q.shift[8];
						2'h1: r_d.sclOe = 1'b0;
						2'h3: begin
							r_d.sclOe = 1'b1;
							r_d.rx = {r_q.rx[6:0], smp};
							r_d.shift = {r_q.shift[7:0], 1'b1};
							r_d.bits = r_q.bits - 4'h1;
							if (r_q.kind != i2cm_pkg::K_RX & r_q.kind != i2cm_pkg::K_ACKSTOP &
								r_q.bits != 4'h1 & r_q.shift[8] & ~smp) begin
								r_d.arbitration_lost_flag = 1'b1;
								r_d.masterOnBus = 1'b1;
								r_d.sclOe = 1'b0;
								r_d.sdaOe = 1'b0;
								r_d.state = i2cm_pkg::ST_IDLE;
							end else if (r_q.bits == 4'h1) begin
								r_d.sdaOe = 1'b0;
								r_d.state = i2cm_pkg::ST_HOLD;
								case (r_q.kind)
									i2cm_pkg::K_ADDR: begin
										r_d.readDir = 1'b0;
										if (!smp & r_q.addr[0]) begin
											r_d.kind = i2cm_pkg::K_RX;
											r_d.shift = 9'h1FF;
											r_d.bits = 4'h8;
											r_d.state = i2cm_pkg::ST_BITS;
										end else begin
											r_d.masterOnBus = 1'b1;
											r_d.received_nack_flag = smp;
										end
									end
									i2cm_pkg::K_TX: begin
										r_d.masterOnBus = 1'b1;
										r_d.received_nack_flag = smp;
									end
									i2cm_pkg::K_RX: begin
										r_d.slaveOnBus = 1'b1;
										r_d.readDir = 1'b1;
										r_d.received_nack_flag = 1'b0;
										r_d.data = {r_q.rx[6:0], smp};
									end
									default: r_d.state = i2cm_pkg::ST_STOP;
								endcase
							end
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end

		if (!r_q.enable) begin
			r_d.state = i2cm_pkg::ST_IDLE;
			r_d.sclOe = 1'b0;
			r_d.sdaOe = 1'b0;
		end
		if (r_q.softRst & r_q.syncCnt == 4'h0) begin
			r_d = '0;
			r_d.sclMeta = sclIn;
			r_d.sclSync = r_q.sclMeta;
			r_d.sdaMeta = sdaIn;
			r_d.sdaSync = r_q.sdaMeta;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			r_q <= '0;
		else if (ce)
			r_q <= r_d;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_HOLD_SCL: assert property (r_q.state == i2cm_pkg::ST_HOLD |-> r_q.sclOe)
		else $error("clock not held low in hold");
	AST_WR_ACK: assert property ($rose(r_q.state == i2cm_pkg::ST_HOLD) && !r_q.readDir && !r_q.received_nack_flag
		|-> r_q.masterOnBus)
		else $error("acked write without master flag");
	AST_RD_SB: assert property ($rose(r_q.slaveOnBus) |-> !r_q.received_nack_flag && r_q.readDir && r_q.sclOe)
		else $error("slave flag without clean hold");
	AST_ARB: assert property ($rose(r_q.arbitration_lost_flag) |-> r_q.masterOnBus && !r_q.sdaOe && !r_q.sclOe)
		else $error("arbitration loss handled wrongly");
	AST_TX: assert property (ce && actData |=> r_q.state == i2cm_pkg::ST_BITS && r_q.bits == 4'h9)
		else $error("data write did not start byte");
	AST_EN_BUSY: assert property (ce && wrOk && paddr == `I2CM_OFS_CTRL_A && !pwdata[0]
		&& pwdata[1] != r_q.enReq |=> r_q.syncEn ##1 r_q.syncEn)
		else $error("enable busy not set");
	AST_SOFT_RESET_BIT_ONLY: assert property (ce && wrOk && paddr == `I2CM_OFS_CTRL_A && pwdata[0]
		|=> r_q.softRst && $stable(r_q.enReq))
		else $error("soft reset write changed other field");
	AST_SOFT_RESET_BIT_ERR: assert property (psel && penable && pwrite && r_q.softRst |-> pslverr)
		else $error("write during reset not refused");
	AST_SOFT_RESET_BIT_END: assert property ($fell(r_q.softRst) |-> !r_q.enable && !r_q.syncEn && !r_q.syncB)
		else $error("soft reset end left state");
	AST_CONTROL_B_REGISTER_PROT: assert property (ce && wrOk && paddr == `I2CM_OFS_CTRL_B && r_q.enable
		|=> r_q.pSmart == $past(r_q.smart))
		else $error("protected field written while enabled");
	AST_SMART: assert property (ce && smartRd |=> r_q.state == i2cm_pkg::ST_BITS
		&& r_q.shift[8] == $past(r_q.ackAction))
		else $error("smart read did not send ack");

	COV_ARB: cover property ($rose(r_q.arbitration_lost_flag));
	COV_RX: cover property ($rose(r_q.slaveOnBus));
	COV_STOP: cover property (cmdFire && r_q.pCmd == i2cm_pkg::CMD_STOP);
endmodule // i2cm_master

// ==== tb/i2cm_slave_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// behavioural slave on the two-wire bus
// ----------------------------------------
module i2cm_slave_model #(
	parameter logic [6:0] DEV = 7'h50
) (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       stretch,
	input  wire logic [7:0] txByte,
	output logic            sclLow,
	output logic            sdaLow,
	output logic [7:0]      rxByte,
	output logic            lastAck
);
	logic [7:0] sh    = 8'h00;
	logic [3:0] n     = 4'h0;
	logic       first = 1'b1;
	logic       hit   = 1'b0;
	logic       rd    = 1'b0;

	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
		rxByte = 8'h00;
		lastAck = 1'b1;
	end

	// start or stop: restart framing, release data
	always @(sda) begin
		if (scl) begin
			n = 4'h0;
			first = 1'b1;
			sdaLow = 1'b0;
		end
	end

	always @(posedge scl) begin
		if (n < 4'h8)
			sh = {sh[6:0], sda};
		if (n == 4'h7)
			rxByte = sh;
		if (n == 4'h8) begin
			lastAck = sda;
			// no ack from master ends the read
			if (rd && !first && sda)
				hit = 1'b0;
			first = 1'b0;
		end
		n = (n == 4'h8) ? 4'h0 : n + 4'h1;
	end

	always @(negedge scl) begin
		if (n == 4'h8 && first) begin
			rd = sh[0];
			hit = (sh[7:1] == DEV);
		end
		if (n == 4'h8)
			sdaLow = first ? hit : (!rd && hit);
		else
			sdaLow = rd && hit && !first && !txByte[3'd7 - n[2:0]];
	end

	// slow answer: hold clock low a while
	always @(negedge scl) begin
		if (stretch) begin
			sclLow = 1'b1;
			#500;
			sclLow = 1'b0;
		end
	end
endmodule // i2cm_slave_model

// ==== tb/i2c_master_packet_control_bench.sv ====
`timescale 1ns/100ps
`include "i2cm_defines.svh"
module i2c_master_packet_control_bench;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic        stretch = 1'b0;
	logic        jam = 1'b0;
	logic [7:0]  txByte = 8'h00;
	logic [31:0] q;
	logic [31:0] r;
	logic        e;
	logic        rdy;
	int          seed;
	int          i;
	int          errors = 0;
	int          testsRun = 0;
	wire  [31:0] prdata;
	wire  [7:0]  rxByte;
	wire         pslverr, sclOe, sdaOe, sclLow, sdaLow, lastAck;
	wire         pready, sclOut, sdaOut;
	wire         scl = !(sclOe | sclLow);
	wire         sda = !(sdaOe | sdaLow | jam);

	always #12.5 clk = ~clk;

	i2cm_master #(.QTR_CYCLES(2), .SYNC_CYCLES(16)) DUT (
		.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));

	i2cm_slave_model #(.DEV(7'h50)) slave (
		.scl(scl), .sda(sda), .stretch(stretch), .txByte(txByte),
		.sclLow(sclLow), .sdaLow(sdaLow), .rxByte(rxByte), .lastAck(lastAck));

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(posedge clk);
		#1;
		penable = 1'b1;
		@(posedge clk);
		q = prdata;
		e = pslverr;
		rdy = pready;
		#1;
		psel = 1'b0;
		penable = 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
		apb(1'b1, a, d);
		check({31'h0, e}, {31'h0, expErr});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
		check({31'h0, rdy}, 32'h1);
	endtask

	function automatic logic [31:0] statusWord(input logic arb, input logic nack, input logic hold);
		statusWord = 32'h0;
		statusWord[`I2CM_BIT_ARB_LOSS] = arb;
		statusWord[`I2CM_BIT_NACK_RX] = nack;
		statusWord[`I2CM_BIT_HOLD] = hold;
	endfunction

	task automatic waitFlag(input logic [31:0] m);
		for (int k = 0; k < 400; k++) begin
			apb(1'b0, `I2CM_OFS_INT_FLAG, 32'h0);
			if ((q & m) !== 32'h0)
				break;
		end
		check(q & m, m);
	endtask

	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#2000000;
		errors++;
		endOfTest();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 40;
		repeat (5) @(posedge clk);
		#1;
		rst_b = 1'b1;
		rdc(`I2CM_OFS_CTRL_B, 32'h0);
		rdc(`I2CM_OFS_STATUS, 32'h0);
		rdc(8'h1C, 32'h0);
		wr(8'h1C, 32'hFFFFFFFF, 1'b0);
		wr(`I2CM_OFS_CTRL_B, 32'h100, 1'b0);
		rdc(`I2CM_OFS_SYNC_BUSY, 32'h4);
		repeat (30) @(posedge clk);
		rdc(`I2CM_OFS_CTRL_B, 32'h100);
		wr(`I2CM_OFS_CTRL_A, 32'h2, 1'b0);
		rdc(`I2CM_OFS_SYNC_BUSY, 32'h2);
		rdc(`I2CM_OFS_CTRL_A, 32'h0);
		repeat (30) @(posedge clk);
		rdc(`I2CM_OFS_CTRL_A, 32'h2);
		rdc(`I2CM_OFS_SYNC_BUSY, 32'h0);
		wr(`I2CM_OFS_CTRL_B, 32'h0, 1'b0);
		repeat (30) @(posedge clk);
		rdc(`I2CM_OFS_CTRL_B, 32'h100);
		check({30'h0, sclOut, sdaOut}, 32'h0);
		$display("test setup done");
		wr(`I2CM_OFS_ADDR, 32'hA2, 1'b0);
		waitFlag(32'h1);
		rdc(`I2CM_OFS_STATUS, statusWord(1'b0, 1'b1, 1'b1));
		check({31'h0, scl}, 32'h0);
		wr(`I2CM_OFS_CTRL_B, 32'h30100, 1'b0);
		repeat (100) @(posedge clk);
		check({30'h0, scl, sda}, 32'h3);
		$display("test address nack done");
		wr(`I2CM_OFS_ADDR, 32'hA0, 1'b0);
		waitFlag(32'h1);
		rdc(`I2CM_OFS_INT_FLAG, 32'h1);
		rdc(`I2CM_OFS_STATUS, 32'h8);
		check({31'h0, scl}, 32'h0);
		for (i = 0; i < 5; i++) begin
			r = $random(seed);
			stretch = r[8];
			wr(`I2CM_OFS_DATA, {24'h0, r[7:0]}, 1'b0);
			waitFlag(32'h1);
			check({24'h0, rxByte}, {24'h0, r[7:0]});
			rdc(`I2CM_OFS_STATUS, 32'h8);
		end
		stretch = 1'b0;
		r = $random(seed);
		txByte = r[7:0];
		wr(`I2CM_OFS_ADDR, 32'hA1, 1'b0);
		waitFlag(32'h2);
		rdc(`I2CM_OFS_STATUS, 32'h8);
		rdc(`I2CM_OFS_DATA, {24'h0, r[7:0]});
		txByte = r[15:8];
		waitFlag(32'h2);
		check({31'h0, lastAck}, 32'h0);
		txByte = r[23:16];
		wr(`I2CM_OFS_CTRL_B, 32'h20100, 1'b0);
		repeat (30) @(posedge clk);
		waitFlag(32'h2);
		check({31'h0, lastAck}, 32'h0);
		wr(`I2CM_OFS_CTRL_B, 32'h40100, 1'b0);
		repeat (30) @(posedge clk);
		rdc(`I2CM_OFS_DATA, {24'h0, r[23:16]});
		waitFlag(32'h2);
		check({31'h0, lastAck}, 32'h1);
		wr(`I2CM_OFS_CTRL_B, 32'h70100, 1'b0);
		repeat (150) @(posedge clk);
		check({30'h0, scl, sda}, 32'h3);
		$display("test transfers done");
		wr(`I2CM_OFS_ADDR, 32'hA0, 1'b0);
		waitFlag(32'h1);
		wr(`I2CM_OFS_DATA, 32'hFF, 1'b0);
		@(negedge scl);
		@(negedge scl);
		@(posedge clk);
		#1;
		jam = 1'b1;
		waitFlag(32'h1);
		rdc(`I2CM_OFS_STATUS, statusWord(1'b1, 1'b0, 1'b0));
		check({30'h0, sclOe, sdaOe}, 32'h0);
		@(posedge clk);
		#1;
		jam = 1'b0;
		wr(`I2CM_OFS_STATUS, 32'h2, 1'b0);
		rdc(`I2CM_OFS_STATUS, 32'h0);
		$display("test arbitration done");
		wr(`I2CM_OFS_CTRL_A, 32'h3, 1'b0);
		rdc(`I2CM_OFS_SYNC_BUSY, 32'h1);
		rdc(`I2CM_OFS_CTRL_A, 32'h1);
		wr(`I2CM_OFS_CTRL_B, 32'h100, 1'b1);
		rdc(`I2CM_OFS_CTRL_B, 32'h0);
		repeat (30) @(posedge clk);
		rdc(`I2CM_OFS_CTRL_A, 32'h0);
		rdc(`I2CM_OFS_SYNC_BUSY, 32'h0);
		rdc(`I2CM_OFS_CTRL_B, 32'h0);
		$display("test soft reset done");
		endOfTest();
	end
endmodule // i2c_master_packet_control_bench
